// ===== design/spcs_pkg.sv
package spcs_pkg;
    localparam logic [7:0] SPCS_CMD_SPR_READ = 8'h80;
    localparam logic [7:0] SPCS_CMD_SPR_OVERRUN = 8'h81;
    localparam logic [7:0] SPCS_CMD_SPR_ON = 8'h82;
    localparam logic [7:0] SPCS_CMD_SPR_OFF = 8'h83;
    localparam logic [7:0] SPCS_CMD_SPR_WRITE = 8'h84;
    localparam logic [7:0] SPCS_CMD_SPR_SWITCH = 8'h85;
    localparam logic [7:0] SPCS_CMD_EXIT = 8'h88;
    localparam logic [7:0] SPCS_CMD_PEN_READ = 8'hc0;
    localparam int SPCS_ST_PEN = 7;
    localparam int SPCS_ST_VBLANK = 6;
    localparam int SPCS_ST_SPRITE = 5;
    localparam int SPCS_ST_FAULT = 4;
    localparam int SPCS_ST_BUSY = 2;
    localparam int SPCS_ST_OBF = 1;
    localparam int SPCS_ST_IBF = 0;
    localparam logic [2:0] SPCS_ATTR_Y_LO = 3'h0;
    localparam logic [2:0] SPCS_ATTR_HEIGHT = 3'h1;
    localparam logic [2:0] SPCS_ATTR_LAST = 3'h7;
    localparam int SPCS_VIS_BIT = 4;
    localparam logic [7:0] SPCS_STATUS_RESET = 8'h00;
    localparam logic [4:0] SPCS_SPRITE_RESET = 5'h00;
    localparam logic [7:0] SPCS_ATTR_RESET = 8'h00;
    localparam logic [1:0] SPCS_HOST_PORT_STATUS = 2'h0;
    localparam logic [1:0] SPCS_HOST_PORT_DATA = 2'h1;
    localparam logic [1:0] SPCS_HOST_PORT_CMD = 2'h2;
    localparam logic [1:0] SPCS_HOST_PORT_PARAM = 2'h3;
    localparam logic [7:0] SPCS_WB_CTRL = 8'h00;
    localparam logic [7:0] SPCS_WB_WDATA = 8'h04;
    localparam logic [7:0] SPCS_WB_RDATA = 8'h08;
    localparam logic [7:0] SPCS_WB_STATUS = 8'h0c;
    typedef enum logic [2:0] {
        SPCS_IDLE = 3'b000,
        SPCS_PARAM = 3'b001,
        SPCS_READ = 3'b010,
        SPCS_WRITE = 3'b011,
        SPCS_HALT = 3'b100
    } spcs_state_type;
endpackage : spcs_pkg

// ===== design/spcs_if.sv
`timescale 1ns/100ps
interface spcs_if;
    logic store_stb;
    logic fetch_stb;
    logic [1:0] port_sel;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ready;
    modport device (input store_stb, input fetch_stb, input port_sel, input wdata,
        output rdata, output ready);
    modport host (output store_stb, output fetch_stb, output port_sel, output wdata,
        input rdata, input ready);
endinterface : spcs_if

// ===== design/spcs_device.sv
`timescale 1ns/100ps
// Summary of operation
// - Read command returns addressed attribute byte
// - Attribute index selects field of record
// - Each taken byte advances attribute, then sprite
// - Read streaming continues until new command
// - Write command stores following parameter bytes
// - Each stored byte advances attribute, then sprite
// - Switch command sets sprite visible bit
// - Overrun query returns flags, clears sprite event
// - Status byte layout for host
// - Input full sets on store, clears consumed
// - Store while input full stalls via ready
// - Output full set on load, cleared fetch/command
// - Fetch before data stalls via ready
// - Busy follows input full and streaming commands
// - Fault halts processing until exit, except the too-few-parameters fault and a surplus parameter during a read
// - Malformed input and bad pen read fault
// - Surplus parameters discarded with fault
// - Too few parameters handling
// - Sprite event updated at vertical blank
// - Vertical blank flag follows blanking
// - Pen hit set on capture, cleared by read
// - Host polls input full before stores, output full for data reads
// - Exit aborts parameters or transfers
module spcs_device
    import spcs_pkg::*;
#(
    parameter int SPRITES = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    spcs_if.device bus,
    input wire logic vblank_i,
    input wire logic line_over_i,
    input wire logic collide_i,
    input wire logic [4:0] excess_index_i,
    input wire logic pen_capture_i,
    input wire logic pen_in_area_i,
    output logic [7:0] status_o
);
    logic [7:0] attr_mem [0:SPRITES*8-1];
    spcs_state_type state_reg;
    logic [7:0] cmd_reg;
    logic [1:0] pcount_reg;
    logic [4:0] sprite_reg;
    logic [2:0] attr_reg;
    logic [7:0] in_reg;
    logic [1:0] in_port_reg;
    logic ibf_reg, obf_reg, busy_reg, fault_reg, ev_reg, vb_reg, pen_reg;
    logic so_reg, col_reg, so_acc_reg, col_acc_reg, vb_d_reg, store_d_reg, fetch_d_reg;
    logic [4:0] ovs_reg, ovs_acc_reg;
    logic [7:0] rdata_reg;
    logic ready_reg;
    logic [7:0] addr;
    logic store_rise, fetch_rise, in_cmd, in_param, known_cmd, consume, fetch_take;

    function automatic logic [1:0] param_count(input logic [7:0] c);
        unique case (c)
            SPCS_CMD_SPR_READ, SPCS_CMD_SPR_WRITE: param_count = 2'd2;
            SPCS_CMD_SPR_SWITCH: param_count = 2'd1;
            default: param_count = 2'd0;
        endcase
    endfunction : param_count

    assign addr = {sprite_reg, attr_reg};
    assign store_rise = bus.store_stb && !store_d_reg;
    assign fetch_rise = bus.fetch_stb && bus.port_sel == SPCS_HOST_PORT_DATA && !fetch_d_reg;
    assign consume = ibf_reg;
    assign in_cmd = consume && in_port_reg == SPCS_HOST_PORT_CMD;
    assign in_param = consume && in_port_reg == SPCS_HOST_PORT_PARAM;
    assign known_cmd = in_reg[7] && (in_reg[6:4] == 3'h0 || in_reg == SPCS_CMD_PEN_READ);
    assign fetch_take = fetch_rise && obf_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            store_d_reg <= 1'b0;
            fetch_d_reg <= 1'b0;
        end else begin
            store_d_reg <= bus.store_stb && (store_d_reg || !ibf_reg);
            fetch_d_reg <= fetch_rise ? obf_reg : fetch_d_reg && bus.fetch_stb;
        end
    end

    // Input buffer latch; a store while full is held off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ibf_reg <= 1'b0;
            in_reg <= 8'h00;
            in_port_reg <= SPCS_HOST_PORT_STATUS;
        end else if (store_rise && !ibf_reg) begin
            ibf_reg <= 1'b1;
            in_reg <= bus.wdata;
            in_port_reg <= bus.port_sel;
        end else if (consume) begin
            ibf_reg <= 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_reg <= 1'b1;
        end else begin
            ready_reg <= !((bus.store_stb && ibf_reg && !store_d_reg)
                || (fetch_rise && !obf_reg));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= SPCS_IDLE;
            cmd_reg <= 8'h00;
            pcount_reg <= 2'd0;
            sprite_reg <= SPCS_SPRITE_RESET;
            attr_reg <= SPCS_ATTR_Y_LO;
            fault_reg <= 1'b0;
            busy_reg <= 1'b0;
            obf_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            if (store_rise && !ibf_reg) begin
                busy_reg <= 1'b1;
            end
            if (fetch_take) begin
                obf_reg <= 1'b0;
            end
            if (in_cmd && in_reg == SPCS_CMD_EXIT) begin
                state_reg <= SPCS_IDLE;
                fault_reg <= 1'b0;
                obf_reg <= 1'b0;
                busy_reg <= 1'b0;
            end else if (in_cmd && state_reg == SPCS_HALT) begin
                obf_reg <= 1'b0;
            end else if (in_cmd) begin
                obf_reg <= 1'b0;
                if (!known_cmd) begin
                    fault_reg <= 1'b1;
                    state_reg <= SPCS_HALT;
                    busy_reg <= 1'b0;
                end else begin
                    if (state_reg == SPCS_PARAM) begin
                        fault_reg <= 1'b1;
                    end
                    cmd_reg <= in_reg;
                    pcount_reg <= 2'd0;
                    attr_reg <= SPCS_ATTR_Y_LO;
                    busy_reg <= 1'b0;
                    state_reg <= SPCS_IDLE;
                    if (param_count(in_reg) != 2'd0) begin
                        state_reg <= SPCS_PARAM;
                        busy_reg <= 1'b1;
                    end else if (in_reg == SPCS_CMD_SPR_OVERRUN) begin
                        rdata_reg <= {1'b0, so_reg, col_reg, ovs_reg};
                        obf_reg <= 1'b1;
                    end else if (in_reg == SPCS_CMD_PEN_READ && !pen_in_area_i) begin
                        fault_reg <= 1'b1;
                        state_reg <= SPCS_HALT;
                    end
                end
            end else if (consume && in_port_reg != SPCS_HOST_PORT_PARAM) begin
                fault_reg <= 1'b1;
                state_reg <= SPCS_HALT;
                busy_reg <= 1'b0;
            end else if (in_param) begin
                unique case (state_reg)
                    SPCS_PARAM: begin
                        pcount_reg <= pcount_reg + 2'd1;
                        if (pcount_reg == 2'd0) begin
                            sprite_reg <= in_reg[4:0];
                        end else begin
                            attr_reg <= in_reg[2:0];
                        end
                        if (cmd_reg == SPCS_CMD_SPR_SWITCH) begin
                            attr_mem[{in_reg[7:3], SPCS_ATTR_HEIGHT}][SPCS_VIS_BIT]
                                <= in_reg[1];
                            state_reg <= SPCS_IDLE;
                            busy_reg <= 1'b0;
                        end else if (pcount_reg == 2'd1 && cmd_reg == SPCS_CMD_SPR_READ) begin
                            rdata_reg <= attr_mem[{sprite_reg, in_reg[2:0]}];
                            obf_reg <= 1'b1;
                            state_reg <= SPCS_READ;
                        end else if (pcount_reg == 2'd1) begin
                            state_reg <= SPCS_WRITE;
                        end
                    end
                    SPCS_WRITE: begin
                        attr_mem[addr] <= in_reg;
                        attr_reg <= attr_reg + 3'd1;
                        if (attr_reg == SPCS_ATTR_LAST) begin
                            sprite_reg <= sprite_reg + 5'd1;
                        end
                    end
                    SPCS_IDLE: begin
                        fault_reg <= 1'b1;
                        state_reg <= SPCS_HALT;
                    end
                    SPCS_READ, SPCS_HALT: begin
                        fault_reg <= 1'b1;
                    end
                    default: begin
                        state_reg <= SPCS_HALT;
                    end
                endcase
            end else if (state_reg == SPCS_READ && fetch_d_reg && !bus.fetch_stb) begin
                // Next byte waits for the strobe to drop, so the taken one stands
                attr_reg <= attr_reg + 3'd1;
                if (attr_reg == SPCS_ATTR_LAST) begin
                    sprite_reg <= sprite_reg + 5'd1;
                end
                rdata_reg <= attr_mem[addr + 8'd1];
                obf_reg <= 1'b1;
            end
        end
    end
    // Sprite event accumulates over a frame, published at blank entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vb_d_reg <= 1'b0;
            ev_reg <= 1'b0;
            so_reg <= 1'b0;
            col_reg <= 1'b0;
            ovs_reg <= 5'h00;
            so_acc_reg <= 1'b0;
            col_acc_reg <= 1'b0;
            ovs_acc_reg <= 5'h00;
        end else begin
            vb_d_reg <= vblank_i;
            if (vblank_i && !vb_d_reg) begin
                so_reg <= so_acc_reg || line_over_i;
                col_reg <= col_acc_reg || collide_i;
                ovs_reg <= ovs_acc_reg;
                so_acc_reg <= 1'b0;
                col_acc_reg <= 1'b0;
                if (so_acc_reg || col_acc_reg || line_over_i || collide_i) begin
                    ev_reg <= 1'b1;
                end
            end else begin
                if (line_over_i && !so_acc_reg) begin
                    ovs_acc_reg <= excess_index_i;
                end
                so_acc_reg <= so_acc_reg || line_over_i;
                col_acc_reg <= col_acc_reg || collide_i;
                if (in_cmd && in_reg == SPCS_CMD_SPR_OVERRUN && state_reg != SPCS_HALT) begin
                    ev_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pen_reg <= 1'b0;
            vb_reg <= 1'b0;
        end else begin
            vb_reg <= vblank_i;
            if (pen_capture_i) begin
                pen_reg <= 1'b1;
            end else if (in_cmd && in_reg == SPCS_CMD_PEN_READ && state_reg != SPCS_HALT) begin
                pen_reg <= 1'b0;
            end
        end
    end
    // Status is pure observation; no flag reacts to reading it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_o <= SPCS_STATUS_RESET;
        end else begin
            status_o <= {pen_reg, vb_reg, ev_reg, fault_reg, 1'b0,
                busy_reg || ibf_reg, obf_reg, ibf_reg};
        end
    end
    assign bus.rdata = (bus.port_sel == SPCS_HOST_PORT_STATUS) ? status_o : rdata_reg;
    assign bus.ready = ready_reg;
endmodule : spcs_device

// ===== design/spcs_host.sv
`timescale 1ns/100ps
module spcs_host
    import spcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    spcs_if.host bus,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef enum logic [2:0] {
        SPCS_H_IDLE = 3'b000,
        SPCS_H_POLL = 3'b001,
        SPCS_H_STROBE = 3'b010,
        SPCS_H_HOLD = 3'b011,
        SPCS_H_DONE = 3'b100,
        SPCS_H_SETTLE = 3'b101
    } spcs_hstate_type;
    spcs_hstate_type hstate_reg;
    logic [7:0] wdata_reg, rdata_reg;
    logic [1:0] port_reg;
    logic is_read_reg, store_reg, fetch_reg, busy_reg;
    logic [1:0] sel_reg;
    logic req;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus.store_stb = store_reg;
    assign bus.fetch_stb = fetch_reg;
    assign bus.port_sel = sel_reg;
    assign bus.wdata = wdata_reg;

    // Wishbone slave: CTRL starts a transfer, others are plain registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            wdata_reg <= 8'h00;
            port_reg <= SPCS_HOST_PORT_STATUS;
            is_read_reg <= 1'b0;
        end else begin
            wb_ack_o <= 1'b0;
            if (req && !(hstate_reg != SPCS_H_IDLE && wb_we_i && wb_adr_i == SPCS_WB_CTRL)) begin
                wb_ack_o <= 1'b1;
                wb_dat_o <= 32'h00000000;
                if (wb_we_i && wb_adr_i == SPCS_WB_WDATA && wb_sel_i[0]) begin
                    wdata_reg <= wb_dat_i[7:0];
                end else if (wb_we_i && wb_adr_i == SPCS_WB_CTRL && wb_sel_i[0]) begin
                    port_reg <= wb_dat_i[1:0];
                    is_read_reg <= wb_dat_i[2];
                end else if (!wb_we_i && wb_adr_i == SPCS_WB_RDATA) begin
                    wb_dat_o <= {24'h000000, rdata_reg};
                end else if (!wb_we_i && wb_adr_i == SPCS_WB_STATUS) begin
                    wb_dat_o <= {31'h00000000, busy_reg};
                end
            end
        end
    end

    // Port cycle: poll status, strobe, wait for ready, release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hstate_reg <= SPCS_H_IDLE;
            store_reg <= 1'b0;
            fetch_reg <= 1'b0;
            sel_reg <= SPCS_HOST_PORT_STATUS;
            rdata_reg <= 8'h00;
            busy_reg <= 1'b0;
        end else begin
            unique case (hstate_reg)
                SPCS_H_IDLE: begin
                    if (req && wb_we_i && wb_adr_i == SPCS_WB_CTRL && wb_sel_i[0]) begin
                        hstate_reg <= SPCS_H_POLL;
                        busy_reg <= 1'b1;
                        sel_reg <= SPCS_HOST_PORT_STATUS;
                    end
                end
                SPCS_H_POLL: begin
                    // Data reads poll output full, though ready alone would also stall them
                    if ((is_read_reg && port_reg == SPCS_HOST_PORT_STATUS)
                        || (is_read_reg ? bus.rdata[SPCS_ST_OBF] : !bus.rdata[SPCS_ST_IBF])) begin
                        hstate_reg <= SPCS_H_STROBE;
                        sel_reg <= port_reg;
                    end
                end
                SPCS_H_STROBE: begin
                    store_reg <= !is_read_reg;
                    fetch_reg <= is_read_reg;
                    hstate_reg <= SPCS_H_SETTLE;
                end
                // Ready is registered, so it answers a strobe one edge late
                SPCS_H_SETTLE: begin
                    hstate_reg <= SPCS_H_HOLD;
                end
                SPCS_H_HOLD: begin
                    if (bus.ready) begin
                        rdata_reg <= bus.rdata;
                        store_reg <= 1'b0;
                        fetch_reg <= 1'b0;
                        hstate_reg <= SPCS_H_DONE;
                    end
                end
                SPCS_H_DONE: begin
                    sel_reg <= SPCS_HOST_PORT_STATUS;
                    busy_reg <= 1'b0;
                    hstate_reg <= SPCS_H_IDLE;
                end
                default: begin
                    hstate_reg <= SPCS_H_IDLE;
                end
            endcase
        end
    end
endmodule : spcs_host

// ===== tb/spcs_checker.sv
`timescale 1ns/100ps
module spcs_checker
    import spcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic store_stb,
    input wire logic fetch_stb,
    input wire logic [1:0] port_sel,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ready,
    input wire logic [7:0] status_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic cmd_store;
    assign cmd_store = store_stb && port_sel == SPCS_HOST_PORT_CMD;
    reset_ready_a: assert property ($fell(rst_i) |-> ready && status_o == SPCS_STATUS_RESET)
        else $error("ready or status wrong after reset");
    ibf_pulse_a: assert property (status_o[SPCS_ST_IBF] |=> !status_o[SPCS_ST_IBF])
        else $error("input full held too long");
    busy_ibf_a: assert property (status_o[SPCS_ST_IBF] |-> status_o[SPCS_ST_BUSY])
        else $error("busy clear while input full");
    spare_bit_a: assert property (status_o[3] == 1'b0)
        else $error("unused status bit set");
    status_port_a: assert property (port_sel == SPCS_HOST_PORT_STATUS |-> rdata == status_o)
        else $error("status port differs from status");
    cmd_obf_a: assert property ($rose(cmd_store) && !status_o[SPCS_ST_IBF]
        && wdata != SPCS_CMD_SPR_OVERRUN |-> ##[1:3] !status_o[SPCS_ST_OBF])
        else $error("command left output full set");
    // Exit byte may still sit on the data lines a few cycles later
    fault_exit_a: assert property ($fell(status_o[SPCS_ST_FAULT])
        |-> $past(wdata) == SPCS_CMD_EXIT
        || $past(wdata, 2) == SPCS_CMD_EXIT || $past(wdata, 3) == SPCS_CMD_EXIT)
        else $error("fault cleared without exit");
    bad_code_a: assert property ($rose(cmd_store) && wdata < 8'h80
        |-> ##[1:4] status_o[SPCS_ST_FAULT])
        else $error("non-command code without fault");
endmodule : spcs_checker

// ===== tb/sprite_cmd_status_port_bench.sv
`timescale 1ns/100ps
module sprite_cmd_status_port_bench;
    import spcs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0] wb_sel = 4'h1;
    logic [31:0] wb_q;
    logic wb_ack;
    logic vblank = 1'b0;
    logic line_over = 1'b0;
    logic collide = 1'b0;
    logic [4:0] excess = 5'h00;
    logic pen_cap = 1'b0;
    logic pen_in = 1'b1;
    logic [7:0] status;
    logic [7:0] mem [32][8];
    logic [7:0] q;
    logic [7:0] q0;
    logic [31:0] t;
    int s;
    int a;
    int n;
    int failures = 0;
    int comparisons = 0;
    always #2 clk_i = ~clk_i;
    spcs_if spcs_if_inst();
    spcs_device #(.SPRITES(32)) spcs_device_inst (.clk_i(clk_i), .rst_i(rst_i),
        .bus(spcs_if_inst), .vblank_i(vblank), .line_over_i(line_over),
        .collide_i(collide), .excess_index_i(excess), .pen_capture_i(pen_cap),
        .pen_in_area_i(pen_in), .status_o(status));
    spcs_host spcs_host_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(spcs_if_inst),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_q), .wb_ack_o(wb_ack));
    spcs_checker spcs_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
        .store_stb(spcs_if_inst.store_stb), .fetch_stb(spcs_if_inst.fetch_stb),
        .port_sel(spcs_if_inst.port_sel), .wdata(spcs_if_inst.wdata),
        .rdata(spcs_if_inst.rdata), .ready(spcs_if_inst.ready), .status_o(status));
    task automatic results;
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    task automatic chk(input string w, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", w, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic [7:0] ad, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        int k = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= ad;
        wb_dat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack !== 1'b1 && k < 100);
        if (k >= 100) failures++;
        r = wb_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb
    // Host polls its own busy bit, so no cycle count is assumed
    task automatic hop(input logic [1:0] p, input logic rd, input logic [7:0] b);
        logic [31:0] x;
        int k = 0;
        wb(SPCS_WB_WDATA, 1'b1, {24'h0, b}, x);
        wb(SPCS_WB_CTRL, 1'b1, {29'h0, rd, p}, x);
        x = 32'h1;
        while (x[0] !== 1'b0 && k < 100) begin
            wb(SPCS_WB_STATUS, 1'b0, 32'h0, x);
            k++;
        end
        if (k >= 100) failures++;
        wb(SPCS_WB_RDATA, 1'b0, 32'h0, x);
        q = x[7:0];
    endtask : hop
    task automatic cmd(input logic [7:0] c);
        hop(SPCS_HOST_PORT_CMD, 1'b0, c);
    endtask : cmd
    task automatic prm(input logic [7:0] b);
        hop(SPCS_HOST_PORT_PARAM, 1'b0, b);
    endtask : prm
    task automatic sbit(input string w, input int i, input logic e);
        hop(SPCS_HOST_PORT_STATUS, 1'b1, 8'h00);
        chk(w, {7'h0, q[i]}, {7'h0, e});
    endtask : sbit
    task automatic spr_wr(input int sp, input int at, input int cnt);
        cmd(SPCS_CMD_SPR_WRITE);
        prm(8'(sp));
        prm(8'(at));
        for (int i = 0; i < cnt; i++) begin
            mem[(sp * 8 + at + i) / 8][(at + i) % 8] = 8'($urandom);
            prm(mem[(sp * 8 + at + i) / 8][(at + i) % 8]);
        end
    endtask : spr_wr
    task automatic spr_rd(input int sp, input int at, input int cnt);
        cmd(SPCS_CMD_SPR_READ);
        prm(8'(sp));
        prm(8'(at));
        for (int i = 0; i < cnt; i++) begin
            hop(SPCS_HOST_PORT_DATA, 1'b1, 8'h00);
            chk("attr", q, mem[(sp * 8 + at + i) / 8][(at + i) % 8]);
        end
        sbit("busy", SPCS_ST_BUSY, 1'b1);
        cmd(SPCS_CMD_EXIT);
        sbit("obf", SPCS_ST_OBF, 1'b0);
        sbit("busy", SPCS_ST_BUSY, 1'b0);
    endtask : spr_rd
    initial begin
        #200000;
        failures++;
        results();
    end
    initial begin
        foreach (mem[i, j]) begin
            mem[i][j] = SPCS_ATTR_RESET;
        end
        void'($urandom(59264));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("reset", status, SPCS_STATUS_RESET);
        wb(8'h40, 1'b0, 32'h0, t);
        chk("unmapped", t[7:0], 8'h00);
        hop(SPCS_HOST_PORT_STATUS, 1'b1, 8'h00);
        q0 = q;
        hop(SPCS_HOST_PORT_STATUS, 1'b1, 8'h00);
        chk("status", q, q0);
        spr_wr(0, 0, 256);
        spr_wr(3, 7, 2);
        spr_rd(3, 6, 4);
        repeat (3) begin
            s = $urandom_range(27);
            a = $urandom_range(7);
            n = $urandom_range(12, 6);
            spr_wr(s, a, n);
            sbit("fault", SPCS_ST_FAULT, 1'b0);
            spr_rd(s, a, n + 2);
        end
        for (int v = 0; v < 2; v++) begin
            s = $urandom_range(31);
            cmd(SPCS_CMD_SPR_SWITCH);
            prm({5'(s), 1'b0, 1'(v), 1'b0});
            mem[s][1][SPCS_VIS_BIT] = 1'(v);
            spr_rd(s, 1, 1);
        end
        cmd(SPCS_CMD_SPR_SWITCH);
        prm({5'h09, 3'b010});
        prm(8'h55);
        sbit("fault", SPCS_ST_FAULT, 1'b1);
        cmd(SPCS_CMD_EXIT);
        sbit("fault", SPCS_ST_FAULT, 1'b0);
        mem[9][1][SPCS_VIS_BIT] = 1'b1;
        spr_rd(9, 1, 1);
        cmd(SPCS_CMD_SPR_WRITE);
        prm(8'h04);
        cmd(SPCS_CMD_EXIT);
        sbit("fault", SPCS_ST_FAULT, 1'b0);
        cmd(SPCS_CMD_SPR_WRITE);
        prm(8'h04);
        cmd(SPCS_CMD_SPR_OVERRUN);
        sbit("fault", SPCS_ST_FAULT, 1'b1);
        cmd(SPCS_CMD_EXIT);
        prm(8'h12);
        sbit("fault", SPCS_ST_FAULT, 1'b1);
        cmd(SPCS_CMD_EXIT);
        for (int i = 0; i < 4; i++) begin
            if (i < 2) begin
                hop(2'(i), 1'b0, SPCS_CMD_SPR_OVERRUN);
            end else begin
                cmd(8'($urandom_range(127)));
            end
            sbit("fault", SPCS_ST_FAULT, 1'b1);
            cmd(SPCS_CMD_EXIT);
            sbit("fault", SPCS_ST_FAULT, 1'b0);
        end
        excess <= 5'($urandom);
        line_over <= 1'b1;
        collide <= 1'b1;
        @(posedge clk_i);
        line_over <= 1'b0;
        collide <= 1'b0;
        vblank <= 1'b1;
        sbit("vblank", SPCS_ST_VBLANK, 1'b1);
        sbit("sprite", SPCS_ST_SPRITE, 1'b1);
        vblank <= 1'b0;
        sbit("vblank", SPCS_ST_VBLANK, 1'b0);
        cmd(SPCS_CMD_SPR_OVERRUN);
        hop(SPCS_HOST_PORT_DATA, 1'b1, 8'h00);
        chk("overrun", q, {2'b01, 1'b1, excess});
        sbit("sprite", SPCS_ST_SPRITE, 1'b0);
        vblank <= 1'b1;
        sbit("sprite", SPCS_ST_SPRITE, 1'b0);
        vblank <= 1'b0;
        pen_cap <= 1'b1;
        @(posedge clk_i);
        pen_cap <= 1'b0;
        sbit("pen", SPCS_ST_PEN, 1'b1);
        cmd(SPCS_CMD_PEN_READ);
        sbit("pen", SPCS_ST_PEN, 1'b0);
        sbit("fault", SPCS_ST_FAULT, 1'b0);
        cmd(SPCS_CMD_EXIT);
        pen_in <= 1'b0;
        cmd(SPCS_CMD_PEN_READ);
        sbit("fault", SPCS_ST_FAULT, 1'b1);
        cmd(SPCS_CMD_EXIT);
        sbit("fault", SPCS_ST_FAULT, 1'b0);
        pen_in <= 1'b1;
        results();
    end
endmodule : sprite_cmd_status_port_bench
